// *** rtl/lsm_pkg.sv ***
// Purpose: shared constants and types of the LIN-mode serial block
// Assumes: 8-bit words, APB register access with one aligned word per register
// Notes:   offsets are byte addresses on the APB bus
package lsm_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_DATA   = 8'h04;
	localparam logic [7:0] OFF_CTRL1  = 8'h08;
	localparam logic [7:0] OFF_CTRL2  = 8'h0C;
	localparam logic [7:0] OFF_CTRL3  = 8'h10;
	localparam logic [7:0] OFF_DIVM   = 8'h14;
	localparam logic [7:0] OFF_DIVF   = 8'h18;
	localparam logic [7:0] OFF_CONV   = 8'h1C;

	// field positions
	localparam int B1_WORD_LEN  = 4;
	localparam int B1_PARITY_EN = 2;
	localparam int B2_RX_IRQ_EN = 5;
	localparam int B2_TX_EN     = 3;
	localparam int B2_RX_EN     = 2;
	localparam int B2_SEND_BRK  = 0;
	localparam int B3_LOCK      = 2;
	localparam int B3_HDET      = 1;

	// reset values
	localparam logic [7:0]  RST_CTRL1 = 8'h00;
	localparam logic [7:0]  RST_CTRL2 = 8'h00;
	localparam logic [7:0]  RST_CONV  = 8'h00;
	localparam logic [11:0] RST_LIN_DIVIDER  = 12'h000;

	// line and timing figures, in bits or oversampling ticks
	localparam int          OVS           = 16;
	localparam logic [3:0]  BRK_TX_BITS   = 4'hD;
	localparam int          BRK_MIN_BITS  = 11;
	localparam logic [4:0]  BRK_EXT_TICKS = 5'(BRK_MIN_BITS * OVS - (OVS * 19) / 2);
	localparam logic [5:0]  TMO_BITS      = 6'h39;
	localparam logic [7:0]  SYNC_VAL      = 8'h55;
	localparam logic [7:0]  BRK_DATA      = 8'h00;
	localparam logic [2:0]  SYNC_EDGES    = 3'h5;
	// deviation limit 10/64 = 15.625 %, written as 5/32
	localparam logic [21:0] DEV_NUM       = 22'h00_0005;
	localparam logic [21:0] DEV_DEN       = 22'h00_0020;

	typedef struct packed {
		logic lin_en;
		logic lin_slave_sel;
		logic header_detect_method;
		logic header_irq_en;
		logic auto_sync_en;
	} lsm_cfg_s;

	localparam lsm_cfg_s RST_CFG = '0;

	typedef struct packed {
		logic tx_empty_flag;
		logic tx_busy;
		logic rx_full_flag;
		logic overrun_flag;
		logic framing_err_flag;
		logic parity_err_flag;
		logic header_err_flag;
		logic rx_busy;
	} lsm_stat_s;

	typedef struct packed {
		logic       chr;
		logic       brk;
		logic       ferr;
		logic [7:0] data;
	} lsm_rxev_s;

	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_STOP, R_LOWW} lsm_rx_e;
	typedef enum logic [2:0] {H_IDLE, H_SYNC, H_MEAS, H_ID, H_BLOCK} lsm_hdr_e;

endpackage

// *** rtl/lsm_lin_serial.sv ***
// Purpose: LIN-mode serial interface with APB registers, break/header handling
// Assumes: APB master; lin_rx/lin_tx go through a LIN transceiver
// Notes:   zero-wait APB, read data registered in the setup cycle
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module lsm_lin_serial (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic [31:0]           prdata,
	// lin line through transceiver
	input  wire logic             lin_rx,
	output logic                  lin_tx,
	// cpu interrupt mask and request
	input  wire logic [1:0]       cpu_int_mask,
	output logic                  irq_req,
	// status snapshot
	output lsm_pkg::lsm_stat_s    stat_out
);
	import lsm_pkg::*;

	function automatic logic at_off(input logic [7:0] a, input logic [7:0] off);
		at_off = (a == off);
	endfunction

	function automatic logic [1:0] lin_par(input logic [7:0] id);
		lin_par = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
	endfunction

	// ---------------- registers and state ----------------
	lsm_cfg_s   cfg_q;
	logic [7:0] ctrl1_q, ctrl2_q, conv_q, data_q;
	logic [11:0] lin_divider_q;
	logic       rxf_q, ovr_q, fe_q, pe_q, herr_q, hdet_q, lock_q, seen_q;
	logic [7:0] tx_hold_q;
	logic       txe_q, brk_pend_q;
	logic [31:0] prdata_q;

	// ---------------- apb decode ----------------
	wire setup   = psel & ~penable;
	wire acc     = psel & penable;
	wire wr      = acc & pwrite;
	wire rd      = acc & ~pwrite;
	wire hit     = at_off(paddr, OFF_STATUS) | at_off(paddr, OFF_DATA) | at_off(paddr, OFF_CTRL1)
	             | at_off(paddr, OFF_CTRL2) | at_off(paddr, OFF_CTRL3) | at_off(paddr, OFF_DIVM)
	             | at_off(paddr, OFF_DIVF) | at_off(paddr, OFF_CONV);
	wire wr_data = wr & at_off(paddr, OFF_DATA);
	wire wr_c2   = wr & at_off(paddr, OFF_CTRL2);
	wire wr_c3   = wr & at_off(paddr, OFF_CTRL3);
	wire wr_divm = wr & at_off(paddr, OFF_DIVM);
	wire wr_divf = wr & at_off(paddr, OFF_DIVF);
	wire rd_stat = rd & at_off(paddr, OFF_STATUS);
	wire rd_data = rd & at_off(paddr, OFF_DATA);
	wire clr_rx  = rd_data & seen_q;

	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata  = prdata_q;

	// ---------------- mode and baud generation ----------------
	wire slave_mode = cfg_q.lin_en & cfg_q.lin_slave_sel;
	// slave: one LIN divider for both directions; otherwise the plain prescaler
	wire [11:0] div_eff = slave_mode ? lin_divider_q : {conv_q, 4'h0};
	logic [12:0] acc_q;
	wire [12:0] acc_add = acc_q + 13'h0010;
	wire tick = (div_eff != 12'h000) && (acc_add >= {1'b0, div_eff});
	logic [3:0] bt_q;
	wire bit_tick = tick & (bt_q == 4'hF);

	// ---------------- receive shifter ----------------
	lsm_rx_e    rx_st_q;
	logic [3:0] smp_q;
	logic [2:0] bc_q;
	logic [7:0] sh_q;
	logic [4:0] low_q;
	logic       rx_prev_q;
	lsm_rxev_s  ev;
	lsm_hdr_e   hs_q;
	wire fall     = rx_prev_q & ~lin_rx;
	// measurement owns the line; no character may be assembled meanwhile
	wire rx_halt  = (hs_q == H_MEAS) | (hs_q == H_BLOCK);
	wire rx_on    = ctrl2_q[B2_RX_EN] & ~rx_halt;
	wire mid      = tick & (smp_q == 4'h7);
	wire last     = tick & (smp_q == 4'hF);

	always_comb begin
		ev      = '0;
		ev.data = sh_q;
		if (rx_st_q == R_STOP && mid && lin_rx)
			ev.chr = 1'b1;
		if (rx_st_q == R_LOWW && lin_rx) begin
			ev.brk  = (sh_q == BRK_DATA) && (low_q >= BRK_EXT_TICKS);
			ev.ferr = ~ev.brk;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_st_q   <= R_IDLE;
			smp_q     <= 4'h0;
			bc_q      <= 3'h0;
			sh_q      <= 8'h00;
			low_q     <= 5'h00;
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= lin_rx;
			if (tick)
				smp_q <= smp_q + 4'h1;
			case (rx_st_q)
				R_IDLE: begin
					smp_q <= 4'h0;
					if (rx_on && fall)
						rx_st_q <= R_START;
				end
				R_START: begin
					if (!rx_on || (mid && lin_rx))
						rx_st_q <= R_IDLE;
					else if (last) begin
						rx_st_q <= R_DATA;
						bc_q    <= 3'h0;
					end
				end
				R_DATA: begin
					if (mid)
						sh_q <= {lin_rx, sh_q[7:1]};
					if (last) begin
						bc_q <= bc_q + 3'h1;
						if (bc_q == 3'h7)
							rx_st_q <= R_STOP;
					end
				end
				R_STOP: begin
					if (mid) begin
						rx_st_q <= lin_rx ? R_IDLE : R_LOWW;
						low_q   <= 5'h00;
					end
				end
				R_LOWW: begin
					// a long low stretch after a zero byte is a break
					if (lin_rx)
						rx_st_q <= R_IDLE;
					else if (tick && low_q != 5'h1F)
						low_q <= low_q + 5'h01;
				end
				default: rx_st_q <= R_IDLE;
			endcase
		end
	end

	// ---------------- synch field measurement ----------------
	logic [14:0] meas_q, gap_q;
	logic [2:0]  edg_q;
	wire [15:0] nom    = {1'b0, lin_divider_q, 3'b000};
	wire [15:0] diff   = ({1'b0, meas_q} > nom) ? ({1'b0, meas_q} - nom) : (nom - {1'b0, meas_q});
	// error only strictly above 15.625 %, first at 16.40625 % at sixteen clocks per bit
	wire dev_err = (22'(diff) * DEV_DEN) > (22'(nom) * DEV_NUM);
	wire meas_run  = (hs_q == H_MEAS) && (edg_q != 3'h0);
	wire meas_edge = (hs_q == H_MEAS) && fall;
	wire meas_done = meas_edge && (edg_q == SYNC_EDGES - 3'h1);
	// a gap shorter than one current bit time means a corrupt synch
	wire gap_err   = meas_edge && (edg_q != 3'h0) && (gap_q < {3'b000, lin_divider_q});
	wire ovf_err   = meas_run && (meas_q == 15'h7FFF);
	wire lock_fall = wr_c3 & lock_q & ~pwdata[B3_LOCK];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meas_q <= 15'h0000;
			gap_q  <= 15'h0000;
			edg_q  <= 3'h0;
		end else if (hs_q != H_MEAS) begin
			edg_q <= 3'h0;
		end else if (meas_edge) begin
			edg_q <= edg_q + 3'h1;
			// edge cycles count too, or every gap and the total come up short
			gap_q  <= 15'h0001;
			meas_q <= (edg_q == 3'h0) ? 15'h0001 : meas_q + 15'h0001;
		end else if (meas_run) begin
			meas_q <= meas_q + 15'h0001;
			if (gap_q != 15'h7FFF)
				gap_q <= gap_q + 15'h0001;
		end
	end

	// ---------------- header sequencing ----------------
	logic       tmo_on_q;
	logic [5:0] tmo_q;
	wire hdr_brk  = slave_mode & ev.brk & (hs_q != H_BLOCK);
	wire tmo_hit  = tmo_on_q & bit_tick & (tmo_q == TMO_BITS);
	wire in_hdr   = (hs_q == H_SYNC) | (hs_q == H_ID);
	wire sync_bad = (hs_q == H_SYNC) & ev.chr & (ev.data != SYNC_VAL);
	wire hdr_ovr  = in_hdr & ev.chr & rxf_q;
	wire lock_err = (gap_err | ovf_err | (tmo_hit & (hs_q == H_MEAS))) & ~lock_fall;
	wire dev_fail = meas_done & dev_err & ~gap_err;
	wire id_rx    = (hs_q == H_ID) & (ev.chr | ev.ferr);
	// the identifier of method 1 is held back until it arrives without a header error
	wire id_ok    = (hs_q == H_ID) & ev.chr;
	wire hdr_err  = sync_bad | hdr_ovr | lock_err | dev_fail | tmo_hit;
	wire id_parity_bad = id_ok & ctrl1_q[B1_PARITY_EN] & (lin_par(ev.data) != ev.data[7:6]);
	wire hide_char = cfg_q.header_detect_method & in_hdr & slave_mode;
	wire brk_deliver = ev.brk & ~(slave_mode & cfg_q.header_detect_method);
	wire chr_deliver = ev.chr & ~hide_char;
	wire hdr_deliver = id_ok & cfg_q.header_detect_method & ~hdr_err;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hs_q     <= H_IDLE;
			tmo_on_q <= 1'b0;
			tmo_q    <= 6'h00;
		end else begin
			if (tmo_on_q && bit_tick)
				tmo_q <= tmo_q + 6'h01;
			if (!slave_mode) begin
				hs_q     <= H_IDLE;
				tmo_on_q <= 1'b0;
			end else if (hdr_brk) begin
				hs_q     <= cfg_q.auto_sync_en ? H_MEAS : H_SYNC;
				tmo_on_q <= cfg_q.header_detect_method | cfg_q.auto_sync_en;
				tmo_q    <= 6'h00;
			end else begin
				case (hs_q)
					H_IDLE: tmo_on_q <= 1'b0;
					H_SYNC: if (hdr_err) hs_q <= H_IDLE;
					        else if (ev.chr) hs_q <= H_ID;
					H_MEAS: begin
						if (lock_err)
							hs_q <= H_BLOCK;
						else if (lock_fall || dev_fail)
							hs_q <= H_IDLE;
						else if (meas_done)
							hs_q <= H_ID;
					end
					H_ID: if (hdr_err || id_rx) hs_q <= H_IDLE;
					H_BLOCK: if (!lock_q) hs_q <= H_IDLE;
					default: hs_q <= H_IDLE;
				endcase
				// any header error, the identifier or a lock release stops the count
				if (hdr_err || id_rx || lock_fall || hs_q == H_BLOCK)
					tmo_on_q <= 1'b0;
			end
		end
	end

	// ---------------- divider: software write wins over measurement ----------------
	wire [11:0] meas_div = meas_q[14:3];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			lin_divider_q <= RST_LIN_DIVIDER;
		else if (wr_divm || wr_divf) begin
			if (wr_divm)
				lin_divider_q[11:4] <= pwdata[7:0];
			if (wr_divf)
				lin_divider_q[3:0] <= pwdata[3:0];
		end else if (meas_done && !dev_err && !gap_err)
			lin_divider_q <= meas_div;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			acc_q <= 13'h0000;
			bt_q  <= 4'h0;
		end else if (tick) begin
			acc_q <= acc_add - {1'b0, div_eff};
			bt_q  <= bt_q + 4'h1;
		end else if (div_eff != 12'h000)
			acc_q <= acc_add;
	end

	// ---------------- flags and control registers ----------------
	// hardware set wins over the software clear in the same cycle, except the lock, where a software release wins
	wire set_rxf  = brk_deliver & hdr_brk | chr_deliver | hdr_deliver | brk_deliver;
	wire set_hdet = (hdr_brk & ~cfg_q.header_detect_method) | hdr_deliver;
	wire set_ovr  = (chr_deliver | hdr_deliver) & rxf_q;
	wire set_fe   = ev.ferr | (ev.brk & ~slave_mode);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_q   <= RST_CFG;
			ctrl1_q <= RST_CTRL1;
			ctrl2_q <= RST_CTRL2;
			conv_q  <= RST_CONV;
			data_q  <= 8'h00;
			rxf_q   <= 1'b0;
			ovr_q   <= 1'b0;
			fe_q    <= 1'b0;
			pe_q    <= 1'b0;
			herr_q  <= 1'b0;
			hdet_q  <= 1'b0;
			lock_q  <= 1'b0;
			seen_q  <= 1'b0;
		end else begin
			if (wr && at_off(paddr, OFF_CTRL1))
				ctrl1_q <= pwdata[7:0];
			if (wr_c2)
				ctrl2_q <= pwdata[7:0];
			if (wr && at_off(paddr, OFF_CONV))
				conv_q <= pwdata[7:0];
			if (wr_c3)
				cfg_q <= pwdata[7:3];
			if (rd_stat)
				seen_q <= 1'b1;
			else if (rd_data)
				seen_q <= 1'b0;
			if (brk_deliver)
				data_q <= BRK_DATA;
			else if (chr_deliver || hdr_deliver)
				data_q <= ev.data;
			rxf_q  <= set_rxf | (rxf_q & ~clr_rx);
			ovr_q  <= set_ovr | (ovr_q & ~clr_rx);
			fe_q   <= set_fe | (fe_q & ~clr_rx);
			pe_q   <= id_parity_bad | (pe_q & ~clr_rx);
			herr_q <= hdr_err | (herr_q & ~clr_rx);
			// software may only drop the lock and the detect flag
			hdet_q <= set_hdet | (hdet_q & ~(wr_c3 & ~pwdata[B3_HDET]));
			lock_q <= lock_err | (lock_q & ~lock_fall);
		end
	end

	// interrupts need both cpu mask bits clear
	wire rx_irq  = ctrl2_q[B2_RX_IRQ_EN] & (rxf_q | ovr_q | herr_q);
	wire hdr_irq = cfg_q.header_irq_en & hdet_q;
	assign irq_req = (cpu_int_mask == 2'b00) & (rx_irq | hdr_irq);

	// ---------------- transmitter ----------------
	logic [13:0] tsh_q;
	logic [3:0]  tbits_q;
	logic        tx_q, sbk_prev_q;
	wire tx_busy  = (tbits_q != 4'h0);
	// slave mode ignores a new break request
	wire brk_req  = ctrl2_q[B2_SEND_BRK] & ~sbk_prev_q & ~slave_mode;
	wire tx_load  = ~tx_busy & bit_tick & ctrl2_q[B2_TX_EN];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tsh_q      <= 14'h3FFF;
			tbits_q    <= 4'h0;
			tx_q       <= 1'b1;
			sbk_prev_q <= 1'b0;
			brk_pend_q <= 1'b0;
			txe_q      <= 1'b1;
			tx_hold_q  <= 8'h00;
		end else begin
			sbk_prev_q <= ctrl2_q[B2_SEND_BRK];
			if (wr_data) begin
				tx_hold_q <= pwdata[7:0];
				txe_q     <= 1'b0;
			end
			if (brk_req)
				brk_pend_q <= 1'b1;
			if (tx_load && brk_pend_q) begin
				tsh_q      <= 14'h2000;
				tbits_q    <= BRK_TX_BITS + 4'h1;
				brk_pend_q <= 1'b0;
			end else if (tx_load && !txe_q) begin
				tsh_q   <= {4'hF, 1'b1, tx_hold_q, 1'b0};
				tbits_q <= 4'hA;
				txe_q   <= 1'b1;
			end else if (tx_busy && bit_tick) begin
				tx_q    <= tsh_q[0];
				tsh_q   <= {1'b1, tsh_q[13:1]};
				tbits_q <= tbits_q - 4'h1;
			end else if (!tx_busy && bit_tick)
				tx_q <= 1'b1;
		end
	end

	assign lin_tx = tx_q;

	// ---------------- read data ----------------
	always_comb begin
		stat_out = '0;
		stat_out.tx_empty_flag    = txe_q;
		stat_out.tx_busy          = tx_busy;
		stat_out.rx_full_flag     = rxf_q;
		stat_out.overrun_flag     = ovr_q;
		stat_out.framing_err_flag = fe_q;
		stat_out.parity_err_flag  = pe_q;
		stat_out.header_err_flag  = herr_q;
		stat_out.rx_busy          = (rx_st_q != R_IDLE) | (hs_q != H_IDLE);
	end

	wire [7:0] rd_mux = at_off(paddr, OFF_STATUS) ? stat_out :
	                    at_off(paddr, OFF_DATA)   ? data_q :
	                    at_off(paddr, OFF_CTRL1)  ? ctrl1_q :
	                    at_off(paddr, OFF_CTRL2)  ? ctrl2_q :
	                    at_off(paddr, OFF_CTRL3)  ? {cfg_q, lock_q, hdet_q, 1'b0} :
	                    at_off(paddr, OFF_DIVM)   ? lin_divider_q[11:4] :
	                    at_off(paddr, OFF_DIVF)   ? {4'h0, lin_divider_q[3:0]} :
	                    at_off(paddr, OFF_CONV)   ? conv_q : 8'h00;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			prdata_q <= 32'h0000_0000;
		else if (setup)
			prdata_q <= {24'h00_0000, rd_mux};
	end

endmodule

`default_nettype wire

// *** bench/lsm_lin_serial_chk.sv ***
// Purpose: port checker for the LIN-mode serial block
// Assumes: zero-wait APB slave, status byte mirrored on stat_out
// Notes:   attached by bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module lsm_lin_serial_chk
	import lsm_pkg::*;
(
	// clock and reset
	input wire logic               clk_sys,
	input wire logic               rstn,
	// apb
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic [31:0]        prdata,
	// line, interrupt, status
	input wire logic               lin_rx,
	input wire logic               lin_tx,
	input wire logic [1:0]         cpu_int_mask,
	input wire logic               irq_req,
	input wire lsm_pkg::lsm_stat_s stat_out
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	wire logic acc     = psel && penable;
	wire logic stat_rd = acc && !pwrite && paddr == OFF_STATUS;
	wire logic data_rd = acc && !pwrite && paddr == OFF_DATA;
	sequence s_stat_rd;
		stat_rd;
	endsequence
	// status read, one idle cycle, then data read
	sequence s_clear;
		s_stat_rd ##3 data_rd;
	endsequence
	a_ready_now: assert property (acc |-> pready)
		else $error("pready low in access");
	a_slverr_map: assert property (acc && paddr > OFF_CONV |-> pslverr)
		else $error("unmapped access not refused");
	a_slverr_ok: assert property (acc && paddr <= OFF_CONV && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	a_prdata_hi: assert property (prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside setup");
	a_irq_masked: assert property (cpu_int_mask != 2'b00 |-> !irq_req)
		else $error("interrupt while masked");
	a_herr_sticky: assert property (stat_out.header_err_flag && !data_rd |=> stat_out.header_err_flag)
		else $error("header error dropped");
	a_full_sticky: assert property (stat_out.rx_full_flag && !data_rd |=> stat_out.rx_full_flag)
		else $error("rx full dropped");
	a_clear_pair: assert property (s_clear |=> !stat_out.header_err_flag)
		else $error("header error not cleared");
endmodule
bind lsm_lin_serial lsm_lin_serial_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .lin_rx(lin_rx), .lin_tx(lin_tx),
	.cpu_int_mask(cpu_int_mask), .irq_req(irq_req), .stat_out(stat_out));
`default_nettype wire

// *** bench/lsm_lin_node.sv ***
// Purpose: LIN master node driving the block's receive line
// Assumes: recessive level is 1, released line pulled high
// Notes:   bit time is given per call so rates can be skewed
`timescale 1ns/10ps
`default_nettype none
module lsm_lin_node (
	// clock
	input wire logic clk_sys,
	// line
	output logic     lin_rx
);
	initial lin_rx = 1'b1;
	task automatic put(input logic v, input int bt);
		@(posedge clk_sys);
		lin_rx <= v;
		repeat (bt - 1) @(posedge clk_sys);
	endtask
	// long low then one recessive bit
	task automatic brk(input int bt);
		repeat (13) put(1'b0, bt);
		put(1'b1, bt);
	endtask
	task automatic chr(input logic [7:0] b, input int bt);
		put(1'b0, bt);
		for (int i = 0; i < 8; i++) put(b[i], bt);
		put(1'b1, bt);
	endtask
endmodule
`default_nettype wire

// *** bench/test_lsm_lin_serial.sv ***
// Purpose: self-checking bench for the LIN-mode serial block
// Assumes: divider mantissa 1 gives sixteen clocks per bit
// Notes:   skewed synch rates probe the deviation limits
`timescale 1ns/10ps
`default_nettype none
module test_lsm_lin_serial;
	import lsm_pkg::*;
	localparam int BT = 16;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [1:0]  cpu_int_mask = 2'b00;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	wire logic   lin_rx;
	logic        lin_tx;
	logic        irq_req;
	lsm_stat_s   stat_out;
	int          num_errors = 0;
	int          comparisons = 0;
	int          run = 0;
	int          last_low = 0;
	logic [7:0]  rv;
	logic        re;

	always #20 clk_sys = ~clk_sys;

	lsm_lin_serial dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .lin_rx(lin_rx), .lin_tx(lin_tx), .cpu_int_mask(cpu_int_mask),
		.irq_req(irq_req), .stat_out(stat_out));
	lsm_lin_node node (.clk_sys(clk_sys), .lin_rx(lin_rx));

	// length of the last low pulse on the transmit line
	always @(posedge clk_sys) begin
		if (lin_tx === 1'b0) begin
			run <= run + 1;
		end else begin
			if (run > 0) last_low <= run;
			run <= 0;
		end
	end

	task automatic wrap_up;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		for (n = 0; n < 8; n++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (n == 8) begin
			chk(1'b0, "bus timeout");
			wrap_up();
		end
		rv = prdata[7:0];
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, string s);
		apb(1'b0, a, 8'h00);
		chk((rv & m) === (e & m), s);
	endtask

	task automatic wait_st(input int b, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge clk_sys);
			if (stat_out[b] === 1'b1) break;
		end
		chk(n < lim, "status bit not set");
		if (n == lim) wrap_up();
	endtask

	// status access then data read
	task automatic clr;
		apb(1'b0, OFF_STATUS, 8'h00);
		apb(1'b0, OFF_DATA, 8'h00);
	endtask

	task automatic t_reset;
		chk(stat_out === 8'h80 && lin_tx === 1'b1 && irq_req === 1'b0, "reset state");
		rd(OFF_STATUS, 8'h80, 8'hFF, "status reset");
		apb(1'b0, 8'h40, 8'h00);
		chk(re === 1'b1 && rv === 8'h00, "unmapped read");
		apb(1'b1, OFF_CTRL1, 8'h00);
	endtask

	task automatic t_master;
		int n;
		apb(1'b1, OFF_CTRL3, 8'h80);
		apb(1'b1, OFF_CONV, 8'h01);
		apb(1'b1, OFF_CTRL2, 8'h09);
		apb(1'b1, OFF_CTRL2, 8'h08);
		repeat (16 * BT) @(posedge clk_sys);
		chk(last_low >= 13 * BT - 2 && last_low <= 13 * BT + 2, "break length");
		apb(1'b1, OFF_DATA, SYNC_VAL);
		wait_st(7, 2 * BT);
		apb(1'b1, OFF_DATA, 8'h0F);
		repeat (24 * BT) @(posedge clk_sys);
		chk(last_low == 4 * BT, "identifier low run");
		apb(1'b1, OFF_CTRL3, 8'hC0);
		apb(1'b1, OFF_DIVM, 8'h01);
		apb(1'b1, OFF_CTRL2, 8'h09);
		for (n = 0; n < 16 * BT && lin_tx === 1'b1; n++) @(posedge clk_sys);
		chk(n == 16 * BT, "slave sent a break");
		apb(1'b1, OFF_CTRL2, 8'h2C);
	endtask

	task automatic t_detect0;
		apb(1'b1, OFF_CTRL3, 8'hD0);
		node.brk(BT);
		wait_st(5, 4 * BT);
		chk(irq_req === 1'b1, "no header irq");
		cpu_int_mask <= 2'b10;
		@(posedge clk_sys);
		@(posedge clk_sys);
		chk(irq_req === 1'b0, "irq while masked");
		cpu_int_mask <= 2'b00;
		rd(OFF_CTRL3, 8'h02, 8'h02, "detected flag");
		rd(OFF_STATUS, 8'h20, 8'h28, "break status");
		rd(OFF_DATA, BRK_DATA, 8'hFF, "break data");
		apb(1'b1, OFF_CTRL3, 8'hC0);
		node.chr(SYNC_VAL, BT);
		wait_st(5, 2 * BT);
		clr();
		node.brk(BT);
		wait_st(5, 4 * BT);
		clr();
		node.chr(8'h54, BT);
		wait_st(1, 4 * BT);
		chk(irq_req === 1'b1, "no error irq");
		clr();
		@(posedge clk_sys);
		chk(stat_out.header_err_flag === 1'b0, "error not cleared");
	endtask

	task automatic t_autosync;
		apb(1'b1, OFF_CTRL3, 8'hC8);
		node.brk(BT);
		wait_st(5, 4 * BT);
		clr();
		node.chr(SYNC_VAL, 18);
		repeat (2 * BT) @(posedge clk_sys);
		chk(stat_out[5] === 1'b0 && stat_out[1] === 1'b0, "synch not measured");
		node.chr(8'h3C, 18);
		wait_st(5, 4 * BT);
		apb(1'b0, OFF_STATUS, 8'h00);
		rd(OFF_DATA, 8'h3C, 8'hFF, "id at measured rate");
		// back to sixteen clocks per bit: the measured fraction must go as well
		apb(1'b1, OFF_DIVM, 8'h01);
		apb(1'b1, OFF_DIVF, 8'h00);
		node.brk(BT);
		wait_st(5, 4 * BT);
		clr();
		node.chr(SYNC_VAL, 7);
		wait_st(1, 4 * BT);
		rd(OFF_CTRL3, 8'h04, 8'h04, "not locked");
		apb(1'b1, OFF_CTRL3, 8'hC8);
		clr();
		@(posedge clk_sys);
		chk(stat_out.header_err_flag === 1'b0, "still in error");
		node.brk(BT);
		wait_st(5, 4 * BT);
		clr();
		node.chr(SYNC_VAL, 19);
		wait_st(1, 4 * BT);
		apb(1'b1, OFF_CTRL3, 8'hC8);
		clr();
	endtask

	task automatic t_detect1;
		int n;
		apb(1'b1, OFF_CTRL1, 8'h04);
		apb(1'b1, OFF_CTRL3, 8'hE0);
		node.brk(BT);
		node.chr(SYNC_VAL, BT);
		rd(OFF_CTRL3, 8'h00, 8'h02, "early detect");
		chk(stat_out.rx_full_flag === 1'b0, "early rx full");
		node.chr(8'hBC, BT);
		wait_st(5, 4 * BT);
		rd(OFF_CTRL3, 8'h02, 8'h02, "no detect");
		rd(OFF_STATUS, 8'h24, 8'h24, "parity");
		rd(OFF_DATA, 8'hBC, 8'hFF, "id data");
		apb(1'b1, OFF_CTRL3, 8'hE0);
		node.brk(BT);
		for (n = 0; n < 70 * BT && stat_out[1] !== 1'b1; n++) @(posedge clk_sys);
		chk(n >= 54 * BT && n <= 59 * BT, "timeout moment");
		if (n == 70 * BT) wrap_up();
		clr();
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_master();
		t_detect0();
		t_autosync();
		t_detect1();
		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge clk_sys);
		chk(1'b0, "run too long");
		wrap_up();
	end
endmodule
`default_nettype wire
